// *** include/pep_pkg.sv ***
// Package with constants, types and helpers of the I2C memory programming engine.
// Functional notes
// - After entry, commands follow address directly.
// - Entry sets pointers to page 48, block 3.
// - Erase-all clears the whole array to zero.
// - Erase-all stretches SCL about 2 ms.
// - Erase-all also clears the lock state.
// - Unerased block program takes exactly 32 bytes.
// - Unerased block write stretches SCL about 2.5 ms.
// - Block pointer wraps 7 to 0, page increments.
// - Single byte program takes offset then data.
// - Single byte program stretches SCL about 4.5 ms.
// - Page select loads page from next byte.
// - Erasing block program stretches about 4.5 ms.
// - Sequences repeat back to back without readdressing.
// - Byte and block clear write zeros.
// - Increments stop at page 31, then wrap zero.
// - Page 48 blocks 0 to 3 are writable.
// - Mode code 00000000 after write address enters mode.
// - Link acts as 7-bit addressed slave receiver.
// - Unerased block program code is 00001011.
package pep_pkg;
    localparam logic [6:0] SLV_ADDR = 7'h50;
    localparam logic [7:0] MODE_CODE = 8'h00;
    localparam logic [7:0] ERASING_BLOCK_PROGRAM_CMD = 8'h01;
    localparam logic [7:0] SINGLE_BYTE_PROGRAM_CMD = 8'h02;
    localparam logic [7:0] BLOCK_CLEAR_CMD = 8'h03;
    localparam logic [7:0] SINGLE_BYTE_CLEAR_CMD = 8'h04;
    localparam logic [7:0] BYTE_FETCH_CMD = 8'h05;
    localparam logic [7:0] ERASE_ALL_CMD = 8'h09;
    localparam logic [7:0] UNERASED_BLOCK_PROGRAM_CMD = 8'h0B;
    localparam logic [7:0] PAGE_SELECT_CMD = 8'h0C;
    localparam logic [7:0] SEQUENTIAL_FETCH_CMD = 8'h0D;
    localparam logic [7:0] BLOCK_ADVANCE_CMD = 8'h0F;
    localparam logic [7:0] NO_CMD = 8'hFF;
    localparam logic [7:0] LOCK_VALUE = 8'hFF;
    localparam logic [7:0] ENTRY_PAGE = 8'h30;
    localparam logic [2:0] ENTRY_BLOCK = 3'h3;
    localparam logic [7:0] LAST_PAGE = 8'h1F;
    localparam logic [5:0] LAST_DATA = 6'h1F;
    localparam int unsigned MEM_DEPTH = 16384;
    localparam int unsigned REF_PERIOD_NS = 50;
    localparam int unsigned ERASE_TIME_NS = 2000000;
    localparam int unsigned WRITE_TIME_NS = 2500000;
    localparam int unsigned ERASE_CYC = ERASE_TIME_NS / REF_PERIOD_NS;
    localparam int unsigned WRITE_CYC = WRITE_TIME_NS / REF_PERIOD_NS;
    localparam int unsigned COMBO_CYC = (ERASE_TIME_NS + WRITE_TIME_NS) / REF_PERIOD_NS;
    localparam int unsigned BUSY_W = 17;

    // Length class of one busy period.
    typedef enum logic [1:0] {OP_ERASE, OP_WRITE, OP_COMBO} pep_op_e;
    // Link protocol states.
    typedef enum logic [2:0] {LK_IDLE, LK_ADDR, LK_RX, LK_ACK, LK_TX, LK_TXACK, LK_SKIP} pep_link_e;

    // Memory pointer: page, block and byte within the block.
    typedef struct packed {
        logic [7:0] page;
        logic [2:0] blk;
        logic [4:0] off;
    } pep_ptr_s;
    localparam pep_ptr_s ENTRY_PTR = '{page: ENTRY_PAGE, blk: ENTRY_BLOCK, off: 5'h00};

    // Pin levels seen on the bus.
    typedef struct packed {
        logic scl;
        logic sda;
    } pep_pin_in_s;
    // Open-drain drive of both bus pins.
    typedef struct packed {
        logic scl_o;
        logic scl_oe;
        logic sda_o;
        logic sda_oe;
    } pep_pin_out_s;

    // Complete state of the link-clock domain.
    typedef struct packed {
        logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
        pep_link_e st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic rd, mack, sda_oe, prog, lock, pend, busy, dseen, req_t;
        logic [7:0] cmd;
        logic [5:0] ncnt;
        logic [7:0] arg;
        pep_ptr_s ptr;
        pep_op_e op;
        logic done_s1, done_s2, done_s3;
        logic clr;
        logic [13:0] clr_idx, clr_last;
    } pep_link_s;

    // Complete state of the reference-clock busy timer.
    typedef struct packed {
        logic req_s1, req_s2, req_s3;
        logic [BUSY_W-1:0] cnt;
        logic done_t;
    } pep_ref_s;

    // Array index of a pointer; page 48 folds onto the upper half.
    function automatic logic [13:0] mem_idx(input pep_ptr_s p);
        return {p.page == ENTRY_PAGE, p.page[4:0], p.blk, p.off};
    endfunction : mem_idx

    // Advances a pointer by one byte or one block, wrapping after page 31.
    function automatic pep_ptr_s ptr_step(input pep_ptr_s p, input logic by_blk);
        pep_ptr_s r;
        r = p;
        if (p.page == LAST_PAGE && p.blk == 3'h7 && (by_blk || p.off == 5'h1F)) begin
            r = '0;
        end else if (by_blk) begin
            r.blk = p.blk + 3'h1;
            if (p.blk == 3'h7) begin
                r.page = p.page + 8'h01;
            end
        end else begin
            {r.page, r.blk, r.off} = {p.page, p.blk, p.off} + 16'h0001;
        end
        return r;
    endfunction : ptr_step
endpackage : pep_pkg

// *** verilog/pep_engine.sv ***
// I2C slave programming engine with memory array and busy timer.
`timescale 1ns/1ps
`default_nettype none
module pep_engine #(
    parameter int unsigned ERASE_CYC = pep_pkg::ERASE_CYC,
    parameter int unsigned WRITE_CYC = pep_pkg::WRITE_CYC,
    parameter int unsigned COMBO_CYC = pep_pkg::COMBO_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic link_clk,
    input wire pep_pkg::pep_pin_in_s pin_i,
    output var pep_pkg::pep_pin_out_s pin_o,
    output logic prog_mode,
    output logic locked
);
    import pep_pkg::*;

    pep_link_s q, n; // Link domain state and its next value.
    pep_ref_s r_q, r_d; // Timer domain state and its next value.
    logic [7:0] mem_q [0:MEM_DEPTH-1]; // Program, data and option memory.
    logic we; // Memory write strobe.
    logic [13:0] waddr; // Memory write index.
    logic [7:0] wdata; // Memory write data.
    logic [7:0] rd_byte; // Byte returned for a read.
    logic scl_rise, scl_fall, start_c, stop_c; // Bus events.
    logic rx_done; // A received data byte is complete.
    pep_ptr_s wp; // Scratch pointer for write addressing.

    // Busy cycles of each operation class.
    function automatic logic [BUSY_W-1:0] op_cycles(input pep_op_e op);
        unique case (op)
            OP_ERASE: return BUSY_W'(ERASE_CYC);
            OP_WRITE: return BUSY_W'(WRITE_CYC);
            OP_COMBO: return BUSY_W'(COMBO_CYC);
            default: return BUSY_W'(COMBO_CYC);
        endcase
    endfunction : op_cycles

    // Link domain next state: pin sync, protocol, commands, clear loop.
    always_comb begin
        n = q;
        we = 1'b0;
        waddr = '0;
        wdata = '0;
        wp = q.ptr;
        n.scl_s1 = pin_i.scl;
        n.scl_s2 = q.scl_s1;
        n.scl_s3 = q.scl_s2;
        n.sda_s1 = pin_i.sda;
        n.sda_s2 = q.sda_s1;
        n.sda_s3 = q.sda_s2;
        n.done_s1 = r_q.done_t;
        n.done_s2 = q.done_s1;
        n.done_s3 = q.done_s2;
        scl_rise = q.scl_s2 & ~q.scl_s3;
        scl_fall = ~q.scl_s2 & q.scl_s3;
        start_c = q.scl_s2 & q.scl_s3 & ~q.sda_s2 & q.sda_s3;
        stop_c = q.scl_s2 & q.scl_s3 & q.sda_s2 & ~q.sda_s3;
        rx_done = !q.busy && !start_c && !stop_c && q.st == LK_RX && scl_fall && q.cnt == 4'h8;
        // Reads outside the lock block return zero while locked.
        if (q.lock && !(q.ptr.page == ENTRY_PAGE && q.ptr.blk == ENTRY_BLOCK)) begin
            rd_byte = 8'h00;
        end else begin
            rd_byte = mem_q[mem_idx(q.ptr)];
        end
        // The clear loop zeroes one byte per cycle until clr_last, starting before busy is set.
        if (q.clr) begin
            we = 1'b1;
            waddr = q.clr_idx;
            n.clr_idx = q.clr_idx + 14'h0001;
            if (q.clr_idx == q.clr_last) begin
                n.clr = 1'b0;
            end
        end
        // The busy period ends when the timer is done and clearing is over.
        if (q.busy) begin
            if (q.done_s2 != q.done_s3) begin
                n.dseen = 1'b1;
            end
            if ((q.dseen || q.done_s2 != q.done_s3) && !q.clr) begin
                n.busy = 1'b0;
            end
        end else if (start_c) begin
            n.st = LK_ADDR;
            n.cnt = '0;
            n.sda_oe = 1'b0;
        end else if (stop_c) begin
            n.st = LK_IDLE;
            n.sda_oe = 1'b0;
        end else begin
            unique case (q.st)
                LK_IDLE, LK_SKIP: begin
                    // Waiting for a Start; nothing is driven.
                end
                LK_ADDR, LK_RX: begin
                    if (scl_rise && q.cnt < 4'h8) begin
                        n.sh = {q.sh[6:0], q.sda_s2};
                        n.cnt = q.cnt + 4'h1;
                    end else if (scl_fall && q.cnt == 4'h8 && q.st == LK_ADDR) begin
                        if (q.sh[7:1] == SLV_ADDR) begin
                            n.st = LK_ACK;
                            n.sda_oe = 1'b1;
                            n.rd = q.sh[0];
                        end else begin
                            n.st = LK_SKIP;
                        end
                    end else if (rx_done) begin
                        n.st = LK_ACK;
                        n.sda_oe = 1'b1;
                        if (!q.prog) begin
                            if (q.sh == MODE_CODE) begin
                                n.prog = 1'b1;
                                n.ptr = ENTRY_PTR;
                                n.lock = mem_q[mem_idx(ENTRY_PTR)] == LOCK_VALUE;
                                n.cmd = NO_CMD;
                            end else begin
                                n.st = LK_SKIP;
                                n.sda_oe = 1'b0;
                            end
                        end else if (q.cmd == NO_CMD) begin
                            n.cmd = q.sh;
                            n.ncnt = '0;
                            if (q.sh == BLOCK_ADVANCE_CMD) begin
                                n.ptr = ptr_step(q.ptr, 1'b1);
                                n.cmd = NO_CMD;
                            end else if (q.sh == ERASE_ALL_CMD) begin
                                n.pend = 1'b1;
                                n.op = OP_ERASE;
                                n.clr = 1'b1;
                                n.clr_idx = '0;
                                n.clr_last = '1;
                                n.lock = 1'b0;
                                n.cmd = NO_CMD;
                            end else if (q.sh != PAGE_SELECT_CMD && q.sh != BYTE_FETCH_CMD &&
                                         q.sh != SINGLE_BYTE_PROGRAM_CMD &&
                                         q.sh != SINGLE_BYTE_CLEAR_CMD &&
                                         q.sh != BLOCK_CLEAR_CMD &&
                                         q.sh != ERASING_BLOCK_PROGRAM_CMD &&
                                         q.sh != UNERASED_BLOCK_PROGRAM_CMD) begin
                                n.cmd = NO_CMD; // Sequential fetch needs no data; unknown codes drop.
                            end
                        end else begin
                            n.ncnt = q.ncnt + 6'h01;
                            n.cmd = NO_CMD;
                            if (q.cmd == PAGE_SELECT_CMD) begin
                                n.ptr = '{page: q.sh, blk: 3'h0, off: 5'h00};
                            end else if (q.cmd == BYTE_FETCH_CMD) begin
                                n.ptr.blk = q.sh[7:5];
                                n.ptr.off = q.sh[4:0];
                            end else if (q.cmd == SINGLE_BYTE_CLEAR_CMD) begin
                                {wp.blk, wp.off} = q.sh;
                                we = 1'b1;
                                waddr = mem_idx(wp);
                                wdata = 8'h00;
                                n.pend = 1'b1;
                                n.op = OP_ERASE;
                            end else if (q.cmd == BLOCK_CLEAR_CMD) begin
                                wp.blk = q.sh[7:5];
                                wp.off = 5'h00;
                                n.clr = 1'b1;
                                n.clr_idx = mem_idx(wp);
                                n.clr_last = mem_idx(wp) + 14'h001F;
                                n.pend = 1'b1;
                                n.op = OP_ERASE;
                            end else if (q.cmd == SINGLE_BYTE_PROGRAM_CMD) begin
                                if (q.ncnt == 6'h00) begin
                                    n.arg = q.sh;
                                    n.cmd = q.cmd;
                                end else begin
                                    {wp.blk, wp.off} = q.arg;
                                    we = 1'b1;
                                    waddr = mem_idx(wp);
                                    wdata = q.sh;
                                    n.pend = 1'b1;
                                    n.op = OP_COMBO;
                                end
                            end else begin
                                // Block programs; page 48 blocks use the same path.
                                wp.off = q.ncnt[4:0];
                                we = 1'b1;
                                waddr = mem_idx(wp);
                                if (q.cmd == UNERASED_BLOCK_PROGRAM_CMD) begin
                                    wdata = q.sh | mem_q[mem_idx(wp)];
                                end else begin
                                    wdata = q.sh;
                                end
                                if (q.ncnt == LAST_DATA) begin
                                    n.pend = 1'b1;
                                    n.op = (q.cmd == UNERASED_BLOCK_PROGRAM_CMD) ?
                                        OP_WRITE : OP_COMBO;
                                end else begin
                                    n.cmd = q.cmd;
                                end
                            end
                        end
                    end
                end
                LK_ACK: begin
                    if (scl_fall) begin
                        n.sda_oe = 1'b0;
                        n.cnt = '0;
                        n.st = LK_RX;
                        if (q.pend) begin
                            n.busy = 1'b1;
                            n.pend = 1'b0;
                            n.dseen = 1'b0;
                            n.req_t = ~q.req_t;
                        end
                        if (q.rd) begin
                            n.st = LK_TX;
                            n.sh = rd_byte;
                            n.sda_oe = ~rd_byte[7];
                            n.ptr = ptr_step(q.ptr, 1'b0);
                        end
                    end
                end
                LK_TX: begin
                    if (scl_rise) begin
                        n.cnt = q.cnt + 4'h1;
                    end else if (scl_fall && q.cnt == 4'h8) begin
                        n.sda_oe = 1'b0;
                        n.st = LK_TXACK;
                    end else if (scl_fall) begin
                        n.sh = {q.sh[6:0], 1'b0};
                        n.sda_oe = ~q.sh[6];
                    end
                end
                LK_TXACK: begin
                    if (scl_rise && q.sda_s2) begin
                        n.st = LK_SKIP;
                    end else if (scl_rise) begin
                        n.mack = 1'b1;
                    end else if (scl_fall && q.mack) begin
                        n.mack = 1'b0;
                        n.cnt = '0;
                        n.st = LK_TX;
                        n.sh = rd_byte;
                        n.sda_oe = ~rd_byte[7];
                        n.ptr = ptr_step(q.ptr, 1'b0);
                    end
                end
            endcase
        end
    end

    // Link domain state register.
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    // Memory write port; contents survive reset.
    always_ff @(posedge link_clk) begin
        if (we) begin
            mem_q[waddr] <= wdata;
        end
    end

    // Timer next state: a request toggle loads the length, zero ends it.
    always_comb begin
        r_d = r_q;
        r_d.req_s1 = q.req_t;
        r_d.req_s2 = r_q.req_s1;
        r_d.req_s3 = r_q.req_s2;
        if (r_q.req_s2 != r_q.req_s3) begin
            r_d.cnt = op_cycles(q.op);
        end else if (r_q.cnt != '0) begin
            r_d.cnt = r_q.cnt - BUSY_W'(1);
            if (r_q.cnt == BUSY_W'(1)) begin
                r_d.done_t = ~r_q.done_t;
            end
        end
    end

    // Timer state register.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    // Pins are open drain; levels come from flip-flops.
    assign pin_o = '{scl_o: 1'b0, scl_oe: q.busy, sda_o: 1'b0, sda_oe: q.sda_oe};
    assign prog_mode = q.prog;
    assign locked = q.lock;

    // A matching address byte is acknowledged.
    property p_addr_ack;
        @(posedge link_clk) disable iff (!rst_n)
        (!q.busy && !start_c && !stop_c && q.st == LK_ADDR && scl_fall && q.cnt == 4'h8 &&
         q.sh[7:1] == SLV_ADDR) |=> (q.sda_oe && q.st == LK_ACK);
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged");

    // The mode code enters programming mode with an acknowledge.
    property p_mode_entry;
        @(posedge link_clk) disable iff (!rst_n)
        (rx_done && !q.prog && q.sh == MODE_CODE) |=> (q.prog && q.sda_oe);
    endproperty
    a_mode_entry: assert property (p_mode_entry) else $error("mode code not taken");

    // Entry leaves the pointer at the lock byte.
    property p_entry_ptr;
        @(posedge link_clk) disable iff (!rst_n)
        $rose(q.prog) |-> (q.ptr == ENTRY_PTR);
    endproperty
    a_entry_ptr: assert property (p_entry_ptr) else $error("entry pointer wrong");

    // Page select loads the page from the data byte.
    property p_page_sel;
        @(posedge link_clk) disable iff (!rst_n)
        (rx_done && q.cmd == PAGE_SELECT_CMD) |=> (q.ptr.page == $past(q.sh) && q.cmd == NO_CMD);
    endproperty
    a_page_sel: assert property (p_page_sel) else $error("page not loaded");

    // Block advance from block 7 moves to the next page.
    property p_blk_adv;
        @(posedge link_clk) disable iff (!rst_n)
        (rx_done && q.prog && q.cmd == NO_CMD && q.sh == BLOCK_ADVANCE_CMD &&
         q.ptr.blk == 3'h7 && q.ptr.page < LAST_PAGE)
        |=> (q.ptr.blk == 3'h0 && q.ptr.page == $past(q.ptr.page) + 8'h01);
    endproperty
    a_blk_adv: assert property (p_blk_adv) else $error("block wrap wrong");

    // Advancing past page 31 block 7 clears every pointer.
    property p_wrap;
        @(posedge link_clk) disable iff (!rst_n)
        (rx_done && q.prog && q.cmd == NO_CMD && q.sh == BLOCK_ADVANCE_CMD &&
         q.ptr.blk == 3'h7 && q.ptr.page == LAST_PAGE) |=> (q.ptr == '0);
    endproperty
    a_wrap: assert property (p_wrap) else $error("pointer did not wrap");

    // Erase-all unlocks and starts clearing at index zero.
    property p_erase_unlock;
        @(posedge link_clk) disable iff (!rst_n)
        (rx_done && q.prog && q.cmd == NO_CMD && q.sh == ERASE_ALL_CMD)
        |=> (!q.lock && q.clr && q.clr_idx == 14'h0000 && q.pend && q.op == OP_ERASE);
    endproperty
    a_erase_unlock: assert property (p_erase_unlock) else $error("erase-all wrong");

    // The 32nd block byte arms a busy period and closes the command.
    property p_blk_count;
        @(posedge link_clk) disable iff (!rst_n)
        (rx_done && q.cmd == UNERASED_BLOCK_PROGRAM_CMD && q.ncnt == LAST_DATA)
        |=> (q.pend && q.op == OP_WRITE && q.cmd == NO_CMD);
    endproperty
    a_blk_count: assert property (p_blk_count) else $error("block count wrong");

    // A launched operation holds SCL low from the acknowledge fall.
    sequence s_launch;
        !q.busy && !start_c && !stop_c && q.st == LK_ACK && scl_fall && q.pend;
    endsequence
    property p_stretch;
        @(posedge link_clk) disable iff (!rst_n)
        s_launch |=> pin_o.scl_oe [*8];
    endproperty
    a_stretch: assert property (p_stretch) else $error("SCL not stretched");

    // A master nack releases SDA and waits for Stop.
    property p_nack;
        @(posedge link_clk) disable iff (!rst_n)
        (!q.busy && !start_c && !stop_c && q.st == LK_TXACK && scl_rise && q.sda_s2)
        |=> (q.st == LK_SKIP && !q.sda_oe);
    endproperty
    a_nack: assert property (p_nack) else $error("nack not handled");

    // A combined request loads the full erase plus write length.
    property p_busy_len;
        @(posedge ref_clk) disable iff (!rst_n)
        (r_q.req_s2 != r_q.req_s3 && q.op == OP_COMBO) |=> (r_q.cnt == BUSY_W'(COMBO_CYC));
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
endmodule : pep_engine
`default_nettype wire

// *** tb/pep_master.sv ***
// Programmer master model that drives the engine's bus pins.
`timescale 1ns/1ps
`default_nettype none
module pep_master (
    input wire logic clk,
    input wire logic scl,
    input wire logic sda,
    output logic scl_low,
    output logic sda_low
);
    int str = 0; // Longest wait for a stretched SCL.
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask : w
    // Releases SCL and waits, bounded, while the device holds it low.
    task automatic rise;
        int n = 0;
        scl_low <= 1'b0;
        w(1);
        while (scl !== 1'b1 && n < 20000) begin
            n++;
            w(1);
        end
        if (n > str) str = n;
    endtask : rise
    // Sends one bit and samples the line in the high phase.
    task automatic bit_x(input logic v, output logic r);
        sda_low <= ~v;
        w(2);
        rise();
        w(2);
        r = sda;
        scl_low <= 1'b1;
        w(2);
    endtask : bit_x
    // One byte plus the ninth bit; d of FFh releases SDA to receive.
    task automatic xb(input logic [7:0] d, input logic a_in, output logic [7:0] q,
                      output logic a);
        for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
        bit_x(a_in, a);
    endtask : xb
    task automatic start;
        sda_low <= 1'b1;
        w(2);
        scl_low <= 1'b1;
        w(2);
    endtask : start
    task automatic stop;
        sda_low <= 1'b1;
        w(2);
        rise();
        w(2);
        sda_low <= 1'b0;
        w(4);
    endtask : stop
endmodule : pep_master
`default_nettype wire

// *** tb/tb_top.sv ***
// Testbench of the programming engine against the master model.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pep_pkg::*;
    localparam int EC = 200, WC = 250, CC = 450;
    logic ref_clk = 1'b0, link_clk = 1'b0, rst_n = 1'b0, m_scl, m_sda, a, pm, lk;
    logic [7:0] q;
    pep_pin_in_s pin_i;
    pep_pin_out_s pin_o;
    int fail_count = 0, n_tests = 0;
    // Open-drain lines with pull-ups.
    assign pin_i = '{scl: ~(pin_o.scl_oe | m_scl), sda: ~(pin_o.sda_oe | m_sda)};
    pep_engine #(.ERASE_CYC(EC), .WRITE_CYC(WC), .COMBO_CYC(CC)) u_pep_engine (
        .ref_clk(ref_clk), .rst_n(rst_n), .link_clk(link_clk), .pin_i(pin_i),
        .pin_o(pin_o), .prog_mode(pm), .locked(lk));
    pep_master u_pep_master (.clk(ref_clk), .scl(pin_i.scl), .sda(pin_i.sda),
        .scl_low(m_scl), .sda_low(m_sda));
    always #25 ref_clk = ~ref_clk;
    initial begin
        #7;
        forever #15 link_clk = ~link_clk;
    end
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            fail_count++;
            $display("[ERR] %0t seen %h exp %h", $time, s, e);
        end
    endtask : check
    task automatic wb(input logic [7:0] d);
        u_pep_master.xb(d, 1'b1, q, a);
        check({31'h0, a}, 32'h0);
    endtask : wb
    task automatic adr(input logic rw);
        u_pep_master.start();
        wb({SLV_ADDR, rw});
    endtask : adr
    // Reads one byte with a closing NACK.
    task automatic rd(input logic [7:0] e);
        adr(1'b1);
        u_pep_master.xb(8'hFF, 1'b1, q, a);
        u_pep_master.stop();
        check({24'h0, q}, {24'h0, e});
    endtask : rd
    task automatic sc(input int lo, input int hi);
        check({31'h0, u_pep_master.str >= lo && u_pep_master.str <= hi}, 32'h1);
    endtask : sc
    task automatic pg(input logic [7:0] p, input int n);
        adr(1'b0);
        wb(PAGE_SELECT_CMD);
        wb(p);
        repeat (n) wb(BLOCK_ADVANCE_CMD);
    endtask : pg
    // Mode entry, erase-all, then a read of the lock byte place.
    task automatic t_entry;
        adr(1'b0);
        wb(MODE_CODE);
        check({31'h0, pm}, 32'h1);
        wb(ERASE_ALL_CMD);
        u_pep_master.str = 0;
        u_pep_master.stop();
        sc(9700, 10000);
        check({31'h0, lk}, 32'h0);
        adr(1'b0);
        wb(SEQUENTIAL_FETCH_CMD);
        u_pep_master.stop();
        rd(8'h00);
    endtask : t_entry
    // Single byte program followed back to back by its fetch.
    task automatic t_byte;
        pg(8'h05, 0);
        wb(SINGLE_BYTE_PROGRAM_CMD);
        wb(8'h23);
        u_pep_master.str = 0;
        wb(8'hA5);
        wb(BYTE_FETCH_CMD);
        wb(8'h23);
        u_pep_master.stop();
        sc(CC - 10, CC + 20);
        rd(8'hA5);
    endtask : t_byte
    // Unerased block program, wrap by block advance, then block clear.
    task automatic t_block;
        pg(8'h02, 3);
        wb(UNERASED_BLOCK_PROGRAM_CMD);
        for (int i = 0; i < 32; i++) begin
            if (i == 31) u_pep_master.str = 0;
            wb(8'h40 + i[7:0]);
        end
        u_pep_master.stop();
        sc(WC - 10, WC + 20);
        pg(8'h02, 3);
        wb(BYTE_FETCH_CMD);
        wb(8'h7F);
        u_pep_master.stop();
        rd(8'h5F);
        pg(8'h01, 11);
        wb(SEQUENTIAL_FETCH_CMD);
        u_pep_master.stop();
        rd(8'h40);
        pg(8'h02, 0);
        wb(BLOCK_CLEAR_CMD);
        u_pep_master.str = 0;
        wb(8'h60);
        u_pep_master.stop();
        sc(EC - 10, EC + 20);
        pg(8'h02, 3);
        wb(SEQUENTIAL_FETCH_CMD);
        u_pep_master.stop();
        rd(8'h00);
    endtask : t_block
    // Option block by explicit page addressing, then one option byte cleared.
    task automatic t_opt;
        pg(8'h30, 0);
        wb(ERASING_BLOCK_PROGRAM_CMD);
        for (int i = 0; i < 32; i++) begin
            if (i == 31) u_pep_master.str = 0;
            wb((i < 8) ? 8'hC0 + i[7:0] : 8'h00);
        end
        u_pep_master.stop();
        sc(CC - 10, CC + 20);
        pg(8'h30, 0);
        wb(BYTE_FETCH_CMD);
        wb(8'h07);
        u_pep_master.stop();
        rd(8'hC7);
        pg(8'h30, 0);
        wb(SINGLE_BYTE_CLEAR_CMD);
        wb(8'h07);
        wb(BYTE_FETCH_CMD);
        wb(8'h07);
        u_pep_master.stop();
        rd(8'h00);
    endtask : t_opt
    // Lock byte place written, then a mid-run reset and a fresh mode entry.
    task automatic t_rst;
        pg(8'h1F, 8);
        wb(PAGE_SELECT_CMD);
        wb(8'h30);
        wb(SINGLE_BYTE_PROGRAM_CMD);
        wb(8'h60);
        wb(8'h5A);
        u_pep_master.stop();
        rst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check({31'h0, pm}, 32'h0);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        adr(1'b0);
        wb(MODE_CODE);
        wb(SEQUENTIAL_FETCH_CMD);
        u_pep_master.stop();
        rd(8'h5A);
    endtask : t_rst
    task automatic print_verdict;
        if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        t_entry();
        t_byte();
        t_block();
        t_opt();
        t_rst();
        print_verdict();
    end
    // Cuts a hang short well beyond the expected run time.
    initial begin
        #3000000;
        fail_count++;
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
